// *** verilog/rgt_pkg.sv ***
// Package of constants and types for the second general-purpose RF timer
package rgt_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_CONTROL     = 6'h19;
    localparam logic [5:0] IDX_RELOAD_HIGH = 6'h1A;
    localparam logic [5:0] IDX_RELOAD_LOW  = 6'h1B;
    localparam logic [5:0] IDX_COUNT_HIGH  = 6'h1C;
    localparam logic [5:0] IDX_COUNT_LOW   = 6'h1D;
    localparam logic [5:0] IDX_IRQ_STATUS  = 6'h30;
    localparam logic [5:0] IDX_IRQ_MASK    = 6'h31;
    localparam logic [5:0] IDX_COMMAND     = 6'h32;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int         BIT_IRQ_UNDERFLOW = 0;
    localparam int         BIT_CMD_START     = 0;
    localparam int         BIT_CMD_STOP      = 1;
    localparam logic [7:0] CTRL_WRITE_MASK   = 8'hBB;
    localparam logic [7:0] RST_CONTROL       = 8'h00;
    localparam logic [7:0] RST_RELOAD_BYTE   = 8'h00;
    localparam logic [7:0] RST_IRQ_MASK      = 8'h00;

    // ------------------------------------------------------------------
    // Count clock generation from the 50 MHz bus clock
    // ------------------------------------------------------------------
    localparam int          PCLK_KHZ      = 50000;
    localparam int          CARRIER_KHZ   = 13560;
    localparam logic [15:0] NCO_STEP      = 16'(CARRIER_KHZ);
    localparam logic [15:0] NCO_MODULUS   = 16'(PCLK_KHZ);
    localparam int          DIV_212K      = 64;
    localparam logic [5:0]  DIV_212K_LAST = 6'(DIV_212K - 1);

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        START_MANUAL  = 2'b00,
        START_TX_END  = 2'b01,
        START_TRIM    = 2'b10,
        START_TRIM_UF = 2'b11
    } rgt_start_t;

    typedef enum logic [1:0] {
        CLK_CARRIER = 2'b00,
        CLK_212K    = 2'b01,
        CLK_T0_UF   = 2'b10,
        CLK_T1_UF   = 2'b11
    } rgt_clk_sel_t;

    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } rgt_state_t;

    typedef struct packed {
        logic         stop_on_receive;
        logic         rsv6;
        rgt_start_t   start_mode_select;
        logic         auto_reload_restart;
        logic         rsv2;
        rgt_clk_sel_t count_clock_select;
    } rgt_ctrl_t;

    typedef struct packed {
        logic t0_underflow;
        logic t1_underflow;
        logic tx_end;
        logic rx_first4;
    } rgt_events_t;

endpackage

// *** verilog/rgt_sync.sv ***
// Three-stage pin synchroniser with filtered rising-edge pulse
`timescale 1ns/1ns
module rgt_sync
(
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);

    logic s1;
    logic s2;
    logic s3;

    // A change is accepted only once stages two and three agree
    wire agree = (s2 == s3);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1    <= 1'b0;
            s2    <= 1'b0;
            s3    <= 1'b0;
            level <= 1'b0;
            rise  <= 1'b0;
        end
        else
        begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            level <= agree ? s3 : level;
            rise  <= agree && s3 && !level;
        end
    end

endmodule

// *** verilog/rgt_timer.sv ***
// Second general-purpose 16-bit down timer with APB registers and interrupt
//
// Summary of operation
// - With stop-on-receive set, halt right after the first 4 received bits.
// - Stop-on-receive is ignored in either oscillator trimming mode.
// - Start mode 00b: no hardware event starts the timer.
// - Start mode 01b: load reload value and run at end of transmission.
// - Start mode 10b: trimming, start/stop on oscillator rising edge, no underflow.
// - Start mode 11b: trimming, start/stop on oscillator rising edge, underflow on.
// - Auto-restart set (except start mode 10b, which stops): at zero reload full 16-bit value and keep counting.
// - Auto-restart clear: count to zero, stop, hold until next start.
// - Every underflow sets this timer's interrupt request flag.
// - Clock select 00b is the 13.56 MHz carrier, 01b is 212 kHz.
// - Clock select 10b/11b count underflows of sibling timer zero/one.
// - A start event loads the counter from high and low reload bytes.
// - Reload writes leave a running count alone until the next start or auto-restart reload.
// - Live count is shown as read-only high and low bytes.
`timescale 1ns/1ns
module rgt_timer
#(
    parameter int APB_AW = 8
)
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [APB_AW-1:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        tx_end,
    input  wire logic        rx_first4,
    input  wire logic        t0_underflow,
    input  wire logic        t1_underflow,
    input  wire logic        low_freq_oscillator,
    output logic             underflow_out,
    output logic             irq
);

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    generate
        if (APB_AW < 8 || APB_AW > 32)
        begin : g_bad_aw
            $error("rgt_timer: APB_AW must be 8 to 32");
        end
    endgenerate

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    rgt_pkg::rgt_ctrl_t   ctrl;
    rgt_pkg::rgt_state_t  state;
    rgt_pkg::rgt_events_t ev;
    logic [7:0]           reload_high_byte;
    logic [7:0]           reload_low_byte;
    logic [15:0]          count;
    logic                 underflow_irq_flag;
    logic                 irq_mask;
    logic [15:0]          nco_acc;
    logic                 carrier_tick;
    logic [5:0]           div_cnt;
    logic                 tick_212k;
    logic                 lfo_rise;

    function automatic logic [5:0] reg_index(input logic [APB_AW-1:0] a);
        reg_index = a[7:2];
    endfunction

    function automatic logic aligned(input logic [APB_AW-1:0] a);
        aligned = (a[1:0] == 2'b00) && (a >> 8 == '0);
    endfunction

    assign ev = '{t0_underflow: t0_underflow, t1_underflow: t1_underflow,
                  tx_end: tx_end, rx_first4: rx_first4};

    // ------------------------------------------------------------------
    // Oscillator pin synchroniser
    // ------------------------------------------------------------------
    rgt_sync u_lfo_sync
    (
        .pclk    (pclk),
        .presetn (presetn),
        .pin     (low_freq_oscillator),
        .level   (),
        .rise    (lfo_rise)
    );

    // ------------------------------------------------------------------
    // Count clock enables
    // ------------------------------------------------------------------
    // Carrier rate is a phase accumulator, so the average is exact while
    // single ticks jitter by one bus cycle.
    wire [16:0] nco_sum  = {1'b0, nco_acc} + {1'b0, rugged_step()};
    wire        nco_wrap = nco_sum >= {1'b0, rgt_pkg::NCO_MODULUS};

    function automatic logic [15:0] rugged_step();
        rugged_step = rgt_pkg::NCO_STEP;
    endfunction

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            nco_acc      <= 16'h0000;
            carrier_tick <= 1'b0;
            div_cnt      <= 6'h00;
            tick_212k    <= 1'b0;
        end
        else
        begin
            nco_acc      <= nco_wrap ? 16'(nco_sum - {1'b0, rgt_pkg::NCO_MODULUS})
                                     : nco_sum[15:0];
            carrier_tick <= nco_wrap;
            div_cnt      <= carrier_tick ? div_cnt + 6'h01 : div_cnt;
            tick_212k    <= carrier_tick && (div_cnt == rgt_pkg::DIV_212K_LAST);
        end
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire [5:0] idx      = reg_index(paddr);
    wire       setup    = psel && !penable;
    wire       wr_go    = psel && penable && pready && pwrite && !pslverr;
    wire       hit      = aligned(paddr) &&
                          (idx == rgt_pkg::IDX_CONTROL ||
                           idx == rgt_pkg::IDX_RELOAD_HIGH ||
                           idx == rgt_pkg::IDX_RELOAD_LOW ||
                           idx == rgt_pkg::IDX_COUNT_HIGH ||
                           idx == rgt_pkg::IDX_COUNT_LOW ||
                           idx == rgt_pkg::IDX_IRQ_STATUS ||
                           idx == rgt_pkg::IDX_IRQ_MASK ||
                           idx == rgt_pkg::IDX_COMMAND);
    wire       wr_ctrl  = wr_go && idx == rgt_pkg::IDX_CONTROL;
    wire       wr_rhi   = wr_go && idx == rgt_pkg::IDX_RELOAD_HIGH;
    wire       wr_rlo   = wr_go && idx == rgt_pkg::IDX_RELOAD_LOW;
    wire       wr_stat  = wr_go && idx == rgt_pkg::IDX_IRQ_STATUS;
    wire       wr_mask  = wr_go && idx == rgt_pkg::IDX_IRQ_MASK;
    // The interrupt follows a mask write at once, not one cycle behind it
    wire       next_irq_mask = wr_mask ? pwdata[0] : irq_mask;
    wire       wr_cmd   = wr_go && idx == rgt_pkg::IDX_COMMAND;
    wire       running  = (state == rgt_pkg::ST_RUN);

    wire [7:0] rd_byte =
        (idx == rgt_pkg::IDX_CONTROL)     ? ctrl :
        (idx == rgt_pkg::IDX_RELOAD_HIGH) ? reload_high_byte :
        (idx == rgt_pkg::IDX_RELOAD_LOW)  ? reload_low_byte :
        (idx == rgt_pkg::IDX_COUNT_HIGH)  ? count[15:8] :
        (idx == rgt_pkg::IDX_COUNT_LOW)   ? count[7:0] :
        (idx == rgt_pkg::IDX_IRQ_STATUS)  ? {7'h00, underflow_irq_flag} :
        (idx == rgt_pkg::IDX_IRQ_MASK)    ? {7'h00, irq_mask} :
        (idx == rgt_pkg::IDX_COMMAND)     ? {7'h00, running} : 8'h00;

    // Answer is registered: access phase always completes in its first cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
        else
        begin
            pready  <= setup;
            pslverr <= setup && !hit;
            prdata  <= (setup && hit && !pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl             <= rgt_pkg::RST_CONTROL;
            reload_high_byte <= rgt_pkg::RST_RELOAD_BYTE;
            reload_low_byte  <= rgt_pkg::RST_RELOAD_BYTE;
            irq_mask         <= rgt_pkg::RST_IRQ_MASK[0];
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= pwdata[7:0] & rgt_pkg::CTRL_WRITE_MASK;
            if (wr_rhi)
                reload_high_byte <= pwdata[7:0];
            if (wr_rlo)
                reload_low_byte <= pwdata[7:0];
            if (wr_mask)
                irq_mask <= pwdata[0];
        end
    end

    // ------------------------------------------------------------------
    // Start, stop and tick selection
    // ------------------------------------------------------------------
    rgt_pkg::rgt_start_t mode;
    assign mode = ctrl.start_mode_select;

    wire [15:0] reload_value_16 = {reload_high_byte, reload_low_byte};
    wire        trim      = mode[1];
    wire        cmd_start = wr_cmd && pwdata[rgt_pkg::BIT_CMD_START];
    wire        cmd_stop  = wr_cmd && pwdata[rgt_pkg::BIT_CMD_STOP];
    wire        tx_start  = (mode == rgt_pkg::START_TX_END) && ev.tx_end;
    wire        lfo_start = trim && lfo_rise && !running;
    wire        lfo_stop  = trim && lfo_rise && running;
    wire        rx_stop   = ev.rx_first4 && ctrl.stop_on_receive && !trim;
    wire        start_evt = cmd_start || tx_start || lfo_start;
    wire        stop_evt  = cmd_stop || lfo_stop || rx_stop;

    wire tick =
        (ctrl.count_clock_select == rgt_pkg::CLK_CARRIER) ? carrier_tick :
        (ctrl.count_clock_select == rgt_pkg::CLK_212K)    ? tick_212k :
        (ctrl.count_clock_select == rgt_pkg::CLK_T0_UF)   ? ev.t0_underflow :
                                                            ev.t1_underflow;

    wire dec_en   = running && !start_evt && !stop_evt && tick;
    wire at_zero  = (count == 16'h0000);
    wire uf_ok    = (mode != rgt_pkg::START_TRIM);
    wire uf_evt   = dec_en && at_zero && uf_ok;
    wire wrap_run = ctrl.auto_reload_restart && uf_ok;

    wire [15:0] next_count =
        start_evt                ? reload_value_16 :
        !dec_en                  ? count :
        !at_zero                 ? count - 16'h0001 :
        wrap_run                 ? reload_value_16 :
                                   count;

    rgt_pkg::rgt_state_t next_state;
    always_comb
    begin
        case (state)
            rgt_pkg::ST_IDLE:
                next_state = start_evt ? rgt_pkg::ST_RUN : rgt_pkg::ST_IDLE;
            rgt_pkg::ST_RUN:
                if (start_evt)
                    next_state = rgt_pkg::ST_RUN;
                else if (stop_evt || (dec_en && at_zero && !wrap_run))
                    next_state = rgt_pkg::ST_IDLE;
                else
                    next_state = rgt_pkg::ST_RUN;
            default:
                next_state = rgt_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Counter, cascade output and interrupt
    // ------------------------------------------------------------------
    wire next_flag = uf_evt || (underflow_irq_flag &&
                     !(wr_stat && pwdata[rgt_pkg::BIT_IRQ_UNDERFLOW]));

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state              <= rgt_pkg::ST_IDLE;
            count              <= 16'h0000;
            underflow_out      <= 1'b0;
            underflow_irq_flag <= 1'b0;
            irq                <= 1'b0;
        end
        else
        begin
            state              <= next_state;
            count              <= next_count;
            underflow_out      <= uf_evt;
            underflow_irq_flag <= next_flag;
            irq                <= next_flag && next_irq_mask;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_loaded;
        ##1 running && count == $past(reload_value_16);
    endsequence

    // Stopped at zero, and one cycle later still at zero unless running again
    sequence s_halted_at_zero;
        !running && count == 16'h0000 ##1 (running || count == 16'h0000);
    endsequence

    wire quiet = !start_evt && !stop_evt;

    AST_RX_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        running && rx_first4 && ctrl.stop_on_receive && !trim && !start_evt
        |=> !running)
        else $error("receive did not stop the timer");

    AST_TRIM_IGNORES_RX: assert property (@(posedge pclk) disable iff (!presetn)
        running && rx_first4 && trim && !lfo_rise && !cmd_stop && !(tick && at_zero)
        |=> running)
        else $error("receive stopped a trimming timer");

    AST_NO_AUTO_START: assert property (@(posedge pclk) disable iff (!presetn)
        !running && mode == rgt_pkg::START_MANUAL && !cmd_start |=> !running)
        else $error("timer started on its own in manual mode");

    AST_TX_START: assert property (@(posedge pclk) disable iff (!presetn)
        mode == rgt_pkg::START_TX_END && tx_end |-> s_loaded)
        else $error("end of transmission did not load and start");

    AST_TRIM_NO_UF: assert property (@(posedge pclk) disable iff (!presetn)
        mode == rgt_pkg::START_TRIM |=> !underflow_out)
        else $error("underflow seen in trimming without underflow");

    AST_TRIM_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        mode == rgt_pkg::START_TRIM_UF && lfo_rise && !cmd_start
        |=> running != $past(running))
        else $error("oscillator edge did not toggle trimming count");

    AST_AUTO_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
        dec_en && at_zero && wrap_run |-> s_loaded)
        else $error("auto restart did not reload");

    AST_STOP_AT_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        dec_en && at_zero && !ctrl.auto_reload_restart |=> s_halted_at_zero)
        else $error("timer did not stop and hold at zero");

    AST_IRQ_SET: assert property (@(posedge pclk) disable iff (!presetn)
        uf_evt |=> underflow_irq_flag && underflow_out)
        else $error("underflow did not raise the flag");

    AST_DECREMENT: assert property (@(posedge pclk) disable iff (!presetn)
        dec_en && !at_zero |=> running && count == $past(count) - 16'h0001)
        else $error("count did not drop by one on a tick");

    AST_RELOAD_ISOLATED: assert property (@(posedge pclk) disable iff (!presetn)
        running && (wr_rhi || wr_rlo) && quiet && !tick |=> count == $past(count))
        else $error("reload write disturbed the running count");

    AST_CTRL_RSV: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl.rsv6 == 1'b0 && ctrl.rsv2 == 1'b0)
        else $error("reserved control bits not zero");

endmodule

// *** tb/rgt_timer_bench.sv ***
// Self-checking testbench for the second general-purpose RF timer
`timescale 1ns/1ns
module rgt_timer_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        tx_end;
    logic        rx_first4;
    logic        t0_underflow;
    logic        t1_underflow;
    logic        low_freq_oscillator;
    logic        underflow_out;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          n_fail;
    int          n_tests;
    int          n_uf;

    rgt_timer #(.APB_AW(8)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_end(tx_end),
        .rx_first4(rx_first4), .t0_underflow(t0_underflow), .t1_underflow(t1_underflow),
        .low_freq_oscillator(low_freq_oscillator), .underflow_out(underflow_out),
        .irq(irq));

    // ------------------------------------------------------------------
    // Clock, watchdog and cascade pulse counter
    // ------------------------------------------------------------------
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        wrap_up();
    end

    always @(posedge pclk)
        if (underflow_out === 1'b1)
            n_uf++;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic chkr(input string nm, input logic [7:0] lo, input logic [7:0] hi,
                        input logic [31:0] g);
        n_tests++;
        if ((^g === 1'bx) || g < lo || g > hi)
        begin
            n_fail++;
            $display("[FAIL] %s expected %0h..%0h seen %0h", nm, lo, hi, g);
        end
    endtask

    // Caller is always just past a rising edge; zero-wait slave is not assumed
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        if (n >= 20)
            chk("pready", 32'h1, 32'h0);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask

    task automatic rdc(input string nm, input logic [5:0] idx, input logic [7:0] e);
        apb(1'b0, idx, 8'h00);
        chk(nm, {24'h000000, e}, rd);
    endtask

    // 0 sibling zero, 1 sibling one, 2 end of transmission, 3 first four bits
    task automatic pulse(input int k);
        case (k)
            0: t0_underflow <= 1'b1;
            1: t1_underflow <= 1'b1;
            2: tx_end <= 1'b1;
            default: rx_first4 <= 1'b1;
        endcase
        @(posedge pclk);
        {t0_underflow, t1_underflow, tx_end, rx_first4} <= 4'h0;
        @(posedge pclk);
    endtask

    // Long enough to clear the pin synchroniser and its filter both ways
    task automatic osc_rise();
        low_freq_oscillator <= 1'b1;
        repeat (8) @(posedge pclk);
        low_freq_oscillator <= 1'b0;
        repeat (8) @(posedge pclk);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        n_fail = 0;
        n_tests = 0;
        n_uf = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {tx_end, rx_first4, t0_underflow, t1_underflow, low_freq_oscillator} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("control", rgt_pkg::IDX_CONTROL, 8'h00);
        rdc("irq_mask", rgt_pkg::IDX_IRQ_MASK, 8'h00);
        wr(rgt_pkg::IDX_CONTROL, 8'hFF);
        rdc("control", rgt_pkg::IDX_CONTROL, 8'hBB);
        apb(1'b0, 6'h00, 8'h00);
        chk("pslverr", 32'h1, {31'h0, err});
        wr(rgt_pkg::IDX_COUNT_HIGH, 8'h55);
        rdc("count_high", rgt_pkg::IDX_COUNT_HIGH, 8'h00);
        wr(rgt_pkg::IDX_IRQ_MASK, 8'h01);
        wr(rgt_pkg::IDX_CONTROL, 8'h02);
        wr(rgt_pkg::IDX_RELOAD_HIGH, 8'h01);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h02);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        rdc("count_high", rgt_pkg::IDX_COUNT_HIGH, 8'h01);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h02);
        pulse(0);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h01);
        // One-shot underflow from a reload of one
        wr(rgt_pkg::IDX_RELOAD_HIGH, 8'h00);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h01);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        pulse(0);
        pulse(0);
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h00);
        rdc("irq_status", rgt_pkg::IDX_IRQ_STATUS, 8'h01);
        chk("irq", 32'h1, {31'h0, irq});
        chk("cascade", 32'd1, n_uf);
        pulse(0);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h00);
        chk("cascade", 32'd1, n_uf);
        wr(rgt_pkg::IDX_IRQ_MASK, 8'h00);
        chk("irq", 32'h0, {31'h0, irq});
        wr(rgt_pkg::IDX_IRQ_STATUS, 8'h01);
        rdc("irq_status", rgt_pkg::IDX_IRQ_STATUS, 8'h00);
        wr(rgt_pkg::IDX_IRQ_MASK, 8'h01);
        // Auto restart reloads and keeps running
        wr(rgt_pkg::IDX_CONTROL, 8'h0A);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        pulse(0);
        pulse(0);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h01);
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h01);
        chk("cascade", 32'd2, n_uf);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        wr(rgt_pkg::IDX_IRQ_STATUS, 8'h01);
        // Reload write while running must wait for the next start
        wr(rgt_pkg::IDX_CONTROL, 8'h02);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h05);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        pulse(0);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h09);
        pulse(0);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h03);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        wr(rgt_pkg::IDX_CONTROL, 8'h03);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h09);
        pulse(0);
        pulse(1);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h08);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        // Hardware starts are ignored in start mode 00b
        wr(rgt_pkg::IDX_CONTROL, 8'h02);
        pulse(2);
        osc_rise();
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h00);
        wr(rgt_pkg::IDX_CONTROL, 8'h92);
        pulse(2);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h09);
        pulse(0);
        pulse(3);
        pulse(0);
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h00);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h08);
        wr(rgt_pkg::IDX_CONTROL, 8'h12);
        pulse(2);
        pulse(3);
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h01);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        // Trimming modes: oscillator edges start and stop
        wr(rgt_pkg::IDX_CONTROL, 8'hA2);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h05);
        osc_rise();
        pulse(3);
        pulse(0);
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h01);
        osc_rise();
        pulse(0);
        rdc("count_low", rgt_pkg::IDX_COUNT_LOW, 8'h04);
        rdc("running", rgt_pkg::IDX_COMMAND, 8'h00);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h01);
        osc_rise();
        pulse(0);
        pulse(0);
        rdc("irq_status", rgt_pkg::IDX_IRQ_STATUS, 8'h00);
        chk("cascade", 32'd2, n_uf);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        wr(rgt_pkg::IDX_CONTROL, 8'h32);
        osc_rise();
        pulse(0);
        pulse(0);
        rdc("irq_status", rgt_pkg::IDX_IRQ_STATUS, 8'h01);
        chk("cascade", 32'd3, n_uf);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        // Internal count clocks, judged by a tolerance band
        wr(rgt_pkg::IDX_CONTROL, 8'h00);
        wr(rgt_pkg::IDX_RELOAD_HIGH, 8'h10);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h00);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        repeat (200) @(posedge pclk);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        rdc("count_high", rgt_pkg::IDX_COUNT_HIGH, 8'h0F);
        apb(1'b0, rgt_pkg::IDX_COUNT_LOW, 8'h00);
        chkr("count_low", 8'hC4, 8'hCE, rd);
        wr(rgt_pkg::IDX_CONTROL, 8'h01);
        wr(rgt_pkg::IDX_RELOAD_HIGH, 8'h00);
        wr(rgt_pkg::IDX_RELOAD_LOW, 8'h10);
        wr(rgt_pkg::IDX_COMMAND, 8'h01);
        repeat (1000) @(posedge pclk);
        wr(rgt_pkg::IDX_COMMAND, 8'h02);
        apb(1'b0, rgt_pkg::IDX_COUNT_LOW, 8'h00);
        chkr("count_low", 8'h0A, 8'h0D, rd);
        wrap_up();
    end
endmodule
